// >>> modem_cfg_defines.svh
`ifndef MODEM_CFG_DEFINES_SVH
`define MODEM_CFG_DEFINES_SVH

// ****************************************
// Register indices and byte addresses (index times four)
// ****************************************
`define IDX_CHANNEL_NUMBER        8'h0A
`define IDX_MODULATION_SYNC       8'h12
`define IDX_PREAMBLE_SPACING_EXP  8'h13
`define IDX_SPACING_MANTISSA      8'h14
`define ADDR_CHANNEL_NUMBER       12'h028
`define ADDR_MODULATION_SYNC      12'h048
`define ADDR_PREAMBLE_SPACING_EXP 12'h04C
`define ADDR_SPACING_MANTISSA     12'h050
`define ADDR_BASE_FREQ            12'h054
`define ADDR_SYNTH_FREQ           12'h058

// ****************************************
// Field positions
// ****************************************
`define MOD_SEL_MSB   6
`define MOD_SEL_LSB   4
`define MANCH_BIT     3
`define SYNC_MSB      2
`define SYNC_LSB      0
`define PREAM_MSB     6
`define PREAM_LSB     4
`define SPC_EXP_MSB   1
`define SPC_EXP_LSB   0

// ****************************************
// Reset values
// ****************************************
`define RST_MODULATION_SYNC      8'h02
`define RST_PREAMBLE_SPACING_EXP 8'h22
`define RST_SPACING_MANTISSA     8'hF8
`define RST_CHANNEL_NUMBER       8'h00
`define RST_BASE_FREQ            24'h1EC4EC

// ****************************************
// Spacing arithmetic
// ****************************************
`define SPC_HIDDEN_ONE 9'h100
`define SPC_SHIFT      18
`define BASE_SHIFT     16
`define AXI_OKAY       2'b00
`define AXI_SLVERR     2'b10

`endif

// >>> modem_cfg_pkg.sv
package modem_cfg_pkg;
  typedef enum logic [2:0] {
    MOD_2FSK = 3'h0,
    MOD_GFSK = 3'h1,
    MOD_OOK  = 3'h3,
    MOD_4FSK = 3'h4
  } modulation_t;
  typedef enum logic [2:0] {
    SYNC_NONE = 3'h0,
    SYNC_16   = 3'h1,
    SYNC_32   = 3'h3
  } sync_mode_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// >>> channel_freq_calc.sv
`timescale 1ns/10ps
`include "modem_cfg_defines.svh"

// ****************************************
// Channel spacing and synthesizer frequency
// ****************************************
// Results are in units of fxosc/2^18 so no precision is lost.
// Base counts in steps four times coarser, hence its two-bit shift.
module channel_freq_calc (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  spacing_mantissa,
  input  wire logic [1:0]  spacing_exponent,
  input  wire logic [7:0]  channel_number,
  input  wire logic [23:0] base_freq,
  output logic      [11:0] spacing_word,
  output logic      [27:0] synth_word
);
  logic [11:0] spacing_ff;
  logic [11:0] nxt_spacing;
  logic [27:0] synth_ff;
  logic [27:0] nxt_synth;
  logic [19:0] product;

  always_comb begin
    nxt_spacing = 12'({`SPC_HIDDEN_ONE + {1'b0, spacing_mantissa}}) << spacing_exponent;
    product     = spacing_ff * channel_number;
    nxt_synth   = {2'b00, base_freq, 2'b00} + {8'h00, product};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spacing_ff <= 12'h000;
      synth_ff   <= 28'h0000000;
    end else begin
      spacing_ff <= nxt_spacing;
      synth_ff   <= nxt_synth;
    end
  end

  assign spacing_word = spacing_ff;
  assign synth_word   = synth_ff;
endmodule // channel_freq_calc

// >>> modem_format_channel_config.sv
// Functional notes
// - Three-bit modulation select, reset 2-FSK
// - Three-bit sync mode select, reset two
// - Minimum preamble bytes from three-bit code
// - Spacing exponent low bits, reset binary 10
// - Spacing from mantissa plus 256, exponent shift
// - Synth frequency is base plus channel number times spacing
// - Spacing mantissa resets to F8
// - Eight-bit channel number register, reset zero
`timescale 1ns/10ps
`include "modem_cfg_defines.svh"

module modem_format_channel_config (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [11:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [11:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output modem_cfg_pkg::modulation_t      modulation_select,
  output logic                            manchester_enable,
  output modem_cfg_pkg::sync_mode_t       sync_mode,
  output logic [4:0]                      min_preamble_bytes,
  output logic [1:0]                      spacing_exponent,
  output logic [7:0]                      spacing_mantissa,
  output logic [7:0]                      channel_number,
  output logic [27:0]                     synth_word
);
  import modem_cfg_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  reg_byte_t   mod_sync_ff;
  reg_byte_t   nxt_mod_sync;
  reg_byte_t   pream_exp_ff;
  reg_byte_t   nxt_pream_exp;
  reg_byte_t   mantissa_ff;
  reg_byte_t   nxt_mantissa;
  reg_byte_t   channel_number_ff;
  reg_byte_t   nxt_channel_number;
  logic [23:0] base_ff;
  logic [23:0] nxt_base;

  // ****************************************
  // AXI handshake state
  // ****************************************
  logic        aw_held_ff;
  logic        nxt_aw_held;
  logic [11:0] awaddr_ff;
  logic [11:0] nxt_awaddr;
  logic        w_held_ff;
  logic        nxt_w_held;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [3:0]  wstrb_ff;
  logic [3:0]  nxt_wstrb;
  logic        bvalid_ff;
  logic        nxt_bvalid;
  logic [1:0]  bresp_ff;
  logic [1:0]  nxt_bresp;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic [2:0]  base_lane_we;
  logic        do_write;

  function automatic logic addr_mapped(input logic [11:0] a);
    case (a)
      `ADDR_CHANNEL_NUMBER, `ADDR_MODULATION_SYNC, `ADDR_PREAMBLE_SPACING_EXP,
      `ADDR_SPACING_MANTISSA, `ADDR_BASE_FREQ, `ADDR_SYNTH_FREQ: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // Code-to-bytes table, fixed by the field encoding
  function automatic logic [4:0] preamble_bytes(input logic [2:0] code);
    case (code)
      3'h0:    preamble_bytes = 5'h02;
      3'h1:    preamble_bytes = 5'h03;
      3'h2:    preamble_bytes = 5'h04;
      3'h3:    preamble_bytes = 5'h06;
      3'h4:    preamble_bytes = 5'h08;
      3'h5:    preamble_bytes = 5'h0C;
      3'h6:    preamble_bytes = 5'h10;
      default: preamble_bytes = 5'h18;
    endcase
  endfunction

  // Synth word is a result, not a setting, so writes to it are refused
  function automatic logic reg_writable(input logic [11:0] a);
    reg_writable = addr_mapped(a) && a != `ADDR_SYNTH_FREQ;
  endfunction

  // ****************************************
  // Channel readies
  // ****************************************
  // Both write channels stall while a response waits: one write in flight
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

  // ****************************************
  // Write channel
  // ****************************************
  // Address and data are parked apart, so either may arrive first
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_held  = w_held_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = reg_writable(awaddr_ff) ? `AXI_OKAY : `AXI_SLVERR;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 12'h000;
      w_held_ff  <= 1'b0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'b00;
    end else begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff  <= nxt_awaddr;
      w_held_ff  <= nxt_w_held;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // ****************************************
  // Base frequency byte lanes
  // ****************************************
  // Lane 3 has no storage behind it, so its strobe is ignored
  // A lane only moves when its strobe is set, so partial writes are safe
  generate
    for (genvar g = 0; g < 3; g++) begin : g_base_lane
      assign base_lane_we[g] = do_write && awaddr_ff == `ADDR_BASE_FREQ && wstrb_ff[g];
    end
  endgenerate

  // ****************************************
  // Register bank
  // ****************************************
  always_comb begin
    nxt_mod_sync  = mod_sync_ff;
    nxt_pream_exp = pream_exp_ff;
    nxt_mantissa  = mantissa_ff;
    nxt_channel_number      = channel_number_ff;
    nxt_base      = base_ff;
    if (do_write && wstrb_ff[0]) begin
      case (awaddr_ff)
        // Manchester with async or 4-FSK is not blocked here; host must avoid it
        `ADDR_MODULATION_SYNC:      nxt_mod_sync = wdata_ff[7:0];
        `ADDR_PREAMBLE_SPACING_EXP: nxt_pream_exp = {wdata_ff[7:4], 2'b00, wdata_ff[1:0]};
        `ADDR_SPACING_MANTISSA:     nxt_mantissa = wdata_ff[7:0];
        `ADDR_CHANNEL_NUMBER:       nxt_channel_number = wdata_ff[7:0];
        default:                    nxt_base = base_ff;
      endcase
    end
    if (base_lane_we[0]) begin
      nxt_base[7:0] = wdata_ff[7:0];
    end
    if (base_lane_we[1]) begin
      nxt_base[15:8] = wdata_ff[15:8];
    end
    // Top two bits stay zero for the usual crystals
    if (base_lane_we[2]) begin
      nxt_base[21:16] = wdata_ff[21:16];
    end
  end

  always_ff @(posedge aclk) begin
    // Reset gives 2-FSK, sync code two and four preamble bytes
    if (!aresetn) begin
      mod_sync_ff  <= `RST_MODULATION_SYNC;
      pream_exp_ff <= `RST_PREAMBLE_SPACING_EXP;
      mantissa_ff  <= `RST_SPACING_MANTISSA;
      channel_number_ff      <= `RST_CHANNEL_NUMBER;
      base_ff      <= `RST_BASE_FREQ;
    end else begin
      mod_sync_ff  <= nxt_mod_sync;
      pream_exp_ff <= nxt_pream_exp;
      mantissa_ff  <= nxt_mantissa;
      channel_number_ff      <= nxt_channel_number;
      base_ff      <= nxt_base;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = addr_mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
      case (s_axi_araddr)
        `ADDR_MODULATION_SYNC:      nxt_rdata = {24'h000000, mod_sync_ff};
        `ADDR_PREAMBLE_SPACING_EXP: nxt_rdata = {24'h000000, pream_exp_ff};
        `ADDR_SPACING_MANTISSA:     nxt_rdata = {24'h000000, mantissa_ff};
        `ADDR_CHANNEL_NUMBER:       nxt_rdata = {24'h000000, channel_number_ff};
        `ADDR_BASE_FREQ:            nxt_rdata = {8'h00, base_ff};
        `ADDR_SYNTH_FREQ:           nxt_rdata = {4'h0, synth_word};
        default:                    nxt_rdata = 32'h00000000;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Read data is held until taken, so a slow master loses nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= 2'b00;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  // ****************************************
  // Response outputs
  // ****************************************
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ****************************************
  // Field outputs
  // ****************************************
  // Reserved codes pass through as-is; their effect is left undefined
  assign modulation_select  = modulation_t'(mod_sync_ff[`MOD_SEL_MSB:`MOD_SEL_LSB]);
  assign manchester_enable  = mod_sync_ff[`MANCH_BIT];
  assign sync_mode          = sync_mode_t'(mod_sync_ff[`SYNC_MSB:`SYNC_LSB]);
  assign min_preamble_bytes = preamble_bytes(pream_exp_ff[`PREAM_MSB:`PREAM_LSB]);
  assign spacing_exponent   = pream_exp_ff[`SPC_EXP_MSB:`SPC_EXP_LSB];
  assign spacing_mantissa   = mantissa_ff;
  assign channel_number     = channel_number_ff;

  // ****************************************
  // Spacing and synthesizer word
  // ****************************************
  // Two register stages: the result trails a spacing change by two cycles, a base or channel change by one
  channel_freq_calc u_freq (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .spacing_mantissa (mantissa_ff),
    .spacing_exponent (pream_exp_ff[`SPC_EXP_MSB:`SPC_EXP_LSB]),
    .channel_number   (channel_number_ff),
    .base_freq        (base_ff),
    .spacing_word     (),
    .synth_word       (synth_word)
  );
endmodule // modem_format_channel_config

// >>> modem_cfg_chk_assertions.sv
`timescale 1ns/10ps
// ****************************************
// Port checks
// ****************************************
module modem_cfg_chk
  import modem_cfg_pkg::*;
(
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire modem_cfg_pkg::modulation_t modulation_select,
  input wire modem_cfg_pkg::sync_mode_t  sync_mode,
  input wire logic [4:0]                 min_preamble_bytes,
  input wire logic [1:0]                 spacing_exponent,
  input wire logic [7:0]                 spacing_mantissa,
  input wire logic [7:0]                 channel_number,
  input wire logic [27:0]                synth_word
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Settled window so the two-stage product has caught up
  sequence s_cfg_still;
    ($stable(spacing_mantissa) && $stable(spacing_exponent) && channel_number == 8'h01) [*3];
  endsequence
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer not released");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer not released");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
  property p_pre_set;
    min_preamble_bytes inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  endproperty
  a_pre_set: assert property (p_pre_set) else $error("bad preamble count");
  // Reset itself is the cause here, so no disable
  property p_rst_fmt;
    disable iff (1'h0) !aresetn |=> modulation_select == MOD_2FSK && sync_mode == 3'h2 && min_preamble_bytes == 5'h04;
  endproperty
  a_rst_fmt: assert property (p_rst_fmt) else $error("format reset wrong");
  property p_rst_spc;
    disable iff (1'h0) !aresetn |=> spacing_exponent == 2'h2 && spacing_mantissa == 8'hF8 && channel_number == 8'h00;
  endproperty
  a_rst_spc: assert property (p_rst_spc) else $error("spacing reset wrong");
  property p_low_bits;
    s_cfg_still |-> synth_word[1:0] == 2'(spacing_mantissa << spacing_exponent);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("synth low bits wrong");
endmodule // modem_cfg_chk

// >>> tb_modem_format_channel_config.sv
`timescale 1ns/10ps
`include "modem_cfg_defines.svh"
module tb_modem_format_channel_config;
  import modem_cfg_pkg::*;
  logic                       aclk = 0;
  logic                       aresetn = 0;
  logic [11:0]                s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]                s_axi_wdata = 0;
  logic                       s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic                       s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                       s_axi_arready, s_axi_rvalid, manchester_enable;
  logic [1:0]                 s_axi_bresp, s_axi_rresp, spacing_exponent;
  logic [31:0]                s_axi_rdata;
  modem_cfg_pkg::modulation_t modulation_select;
  modem_cfg_pkg::sync_mode_t  sync_mode;
  logic [4:0]                 min_preamble_bytes;
  logic [7:0]                 spacing_mantissa, channel_number;
  logic [27:0]                synth_word;
  logic [33:0]                rq[$];
  logic [1:0]                 bq[$];
  int                         n_fail = 0, num_checks = 0, cyc = 0, seed = 2173;

  modem_format_channel_config u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .modulation_select, .manchester_enable, .sync_mode, .min_preamble_bytes, .spacing_exponent,
    .spacing_mantissa, .channel_number, .synth_word);

  always #20 aclk = ~aclk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task test_done;
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Leading edge keeps two tasks from driving one signal in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, bq.pop_front());
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    logic [7:0]  v, m;
    logic [1:0]  e;
    logic [21:0] b;
    logic [27:0] x;
    logic [2:0]  mods[4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [2:0]  syncs[3] = '{3'h0, 3'h1, 3'h3};
    logic [4:0]  pre_tab[8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
    logic [7:0]  chans[4] = '{8'h01, 8'h00, 8'h5A, 8'hFF};
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`ADDR_MODULATION_SYNC, 34'h02);
    rd(`ADDR_PREAMBLE_SPACING_EXP, 34'h22);
    rd(`ADDR_SPACING_MANTISSA, 34'hF8);
    rd(`ADDR_CHANNEL_NUMBER, 34'h00);
    rd(`ADDR_SYNTH_FREQ, 34'h07B13B0);
    chk(min_preamble_bytes, 5'h04);
    for (int i = 0; i < 4; i++) begin
      // Manchester stays off with 4-FSK
      v = {1'($random(seed)), mods[i], mods[i] != 3'h4 && 1'($random(seed)), syncs[i % 3]};
      wr(`ADDR_MODULATION_SYNC, {24'h0, v}, `AXI_OKAY);
      rd(`ADDR_MODULATION_SYNC, {26'h0, v});
      chk({modulation_select, manchester_enable, sync_mode}, v[6:0]);
    end
    for (int k = 0; k < 8; k++) begin
      v = {1'($random(seed)), 3'(k), 4'($random(seed))};
      wr(`ADDR_PREAMBLE_SPACING_EXP, {24'h0, v}, `AXI_OKAY);
      rd(`ADDR_PREAMBLE_SPACING_EXP, {26'h0, v & 8'hF3});
      chk(min_preamble_bytes, pre_tab[k]);
    end
    for (int k = 0; k < 4; k++) begin
      b = 22'($random(seed));
      m = 8'($random(seed));
      e = 2'($random(seed));
      wr(`ADDR_BASE_FREQ, {10'h3, b}, `AXI_OKAY);
      rd(`ADDR_BASE_FREQ, {12'h0, b});
      wr(`ADDR_SPACING_MANTISSA, {24'h0, m}, `AXI_OKAY);
      wr(`ADDR_PREAMBLE_SPACING_EXP, {30'h0, e}, `AXI_OKAY);
      wr(`ADDR_CHANNEL_NUMBER, {24'h0, chans[k]}, `AXI_OKAY);
      rd(`ADDR_CHANNEL_NUMBER, {26'h0, chans[k]});
      x = {b, 2'h0} + ((12'h100 + m) << e) * chans[k];
      rd(`ADDR_SYNTH_FREQ, {6'h0, x});
      chk({spacing_mantissa, spacing_exponent, channel_number}, {m, e, chans[k]});
      chk(synth_word, x);
    end
    wr(12'h0FC, 32'hFFFFFFFF, `AXI_SLVERR);
    wr(`ADDR_SYNTH_FREQ, 32'h0, `AXI_SLVERR);
    rd(`ADDR_SYNTH_FREQ, {6'h0, x});
    rd(12'h0FC, {`AXI_SLVERR, 32'h0});
    repeat (2) @(posedge aclk);
    test_done();
  end
endmodule // tb_modem_format_channel_config

bind modem_format_channel_config modem_cfg_chk u_chk (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .modulation_select, .sync_mode, .min_preamble_bytes, .spacing_exponent,
  .spacing_mantissa, .channel_number, .synth_word);
